// [core/sco_pkg.sv]
// Shared constants and types for the clock oscillator control block
package sco_pkg;

    localparam int CLK_HZ = 10_000_000;
    localparam int SETTLE_US = 100;
    localparam int SETTLE_CYC_RAW = (SETTLE_US * (CLK_HZ / 1_000_000));
    localparam int SETTLE_CYC = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;
    localparam int OST_CYC = 1024;
    localparam int CNT_W = 16;

    localparam logic [1:0] PIN_PORT = 2'h0;
    localparam logic [1:0] PIN_XTAL = 2'h1;
    localparam logic [1:0] PIN_EXT = 2'h3;
    localparam logic [1:0] AMP_ULP = 2'h2;

    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] RUN_RST = 8'hC0;

    localparam int MAIN_SEL_HI = 7;
    localparam int MAIN_SEL_LO = 6;
    localparam int SUB_SEL_HI = 5;
    localparam int SUB_SEL_LO = 4;
    localparam int AMP_HI = 2;
    localparam int AMP_LO = 1;
    localparam int MAIN_AMP = 0;
    localparam int MAIN_OSC_STOP_BIT = 7;
    localparam int XSTOP_BIT = 6;
    localparam int HSTOP_BIT = 0;

    typedef struct packed {
        logic main_ext_clock_select;
        logic main_osc_pin_select;
        logic sub_ext_clock_select;
        logic sub_osc_pin_select;
        logic reserved3;
        logic sub_amp_mode_hi;
        logic sub_amp_mode_lo;
        logic main_amp_high;
    } sco_mode_t;

    typedef struct packed {
        logic main_osc_stop;
        logic sub_osc_stop;
        logic [4:0] reserved;
        logic fast_internal_osc_stop;
    } sco_run_t;

    typedef struct packed {
        logic port_mode;
        logic xtal_en;
        logic ext_in_en;
    } sco_pins_t;

    typedef enum logic [1:0] {
        SRC_FAST,
        SRC_MAIN,
        SRC_SUB
    } sco_src_t;

    typedef enum logic [1:0] {
        ST_SETTLE,
        ST_RUN
    } sco_state_t;

endpackage : sco_pkg

// [core/sco_clock_ctrl.sv]
// Clock source control: oscillator modes, start/stop, CPU clock bring-up
// What this block does
// - Main pin mode from bits 7:6
// - Sub pin mode from bits 5:4
// - Mode 0,0 leaves pins as input ports
// - Sub amp 1,0 selects ultra-low power
// - Fast internal osc follows stop bit 0
// - Fast osc frequency from option byte code
// - Fast osc starts itself after reset
// - Slow osc never feeds the CPU
// - Slow osc runs with watchdog or select
// - Slow osc stops when both are off
// - CPU starts on fast osc after settling
// - Derive main, sub and CPU clock selects
// - External main input needs no wait
// - Mode register accepts one write per reset
// - Clearing main stop starts main crystal when bit 6 is set
// - Sub bits reset only by power-on
`timescale 1ns/1ps
module sco_clock_ctrl (
    input wire logic mclk,
    input wire logic rst,
    input wire logic por,
    input wire logic mode_wr,
    input wire sco_pkg::sco_mode_t mode_wdata,
    input wire logic run_wr,
    input wire sco_pkg::sco_run_t run_wdata,
    input wire logic [3:0] freq_option,
    input wire logic wdt_running,
    input wire logic slow_clock_source_select,
    input wire sco_pkg::sco_src_t cpu_src_req,
    output sco_pkg::sco_mode_t clock_mode_register,
    output sco_pkg::sco_run_t clock_run_control_register,
    output logic mode_locked,
    output sco_pkg::sco_pins_t main_pins,
    output sco_pkg::sco_pins_t sub_pins,
    output logic sub_ultra_low_power,
    output logic main_osc_run,
    output logic sub_osc_run,
    output logic fast_osc_run,
    output logic [4:0] fast_osc_mhz,
    output logic fast_freq_bad,
    output logic slow_osc_run,
    output logic [sco_pkg::CNT_W-1:0] stabilization_counter_status,
    output logic main_stable,
    output logic cpu_run,
    output sco_pkg::sco_src_t cpu_clk_src
);
    import sco_pkg::*;

    // Option code to MHz; zero means a prohibited code
    function automatic logic [4:0] freq_decode(input logic [3:0] code);
        case (code)
            4'h0: freq_decode = 5'h18;
            4'h9: freq_decode = 5'h10;
            4'h1: freq_decode = 5'h0C;
            4'hA: freq_decode = 5'h08;
            4'h2: freq_decode = 5'h06;
            4'hB: freq_decode = 5'h04;
            4'h3: freq_decode = 5'h03;
            4'hC: freq_decode = 5'h02;
            4'hD: freq_decode = 5'h01;
            default: freq_decode = 5'h00;
        endcase
    endfunction : freq_decode

    function automatic sco_pins_t pins_decode(input logic ext, input logic sel);
        pins_decode.port_mode = ({ext, sel} == PIN_PORT);
        pins_decode.xtal_en = ({ext, sel} == PIN_XTAL);
        pins_decode.ext_in_en = ({ext, sel} == PIN_EXT);
    endfunction : pins_decode

    sco_mode_t mode_q, mode_d;
    sco_run_t run_q, run_d;
    logic locked_q, locked_d;

    // Register group
    always_comb begin
        mode_d = mode_q;
        run_d = run_q;
        locked_d = locked_q;
        if (rst) begin
            locked_d = 1'b0;
            mode_d.main_ext_clock_select = MODE_RST[MAIN_SEL_HI];
            mode_d.main_osc_pin_select = MODE_RST[MAIN_SEL_LO];
            mode_d.main_amp_high = MODE_RST[MAIN_AMP];
            run_d.main_osc_stop = RUN_RST[MAIN_OSC_STOP_BIT];
            run_d.fast_internal_osc_stop = RUN_RST[HSTOP_BIT];
            if (por) begin
                mode_d.sub_ext_clock_select = MODE_RST[SUB_SEL_HI];
                mode_d.sub_osc_pin_select = MODE_RST[SUB_SEL_LO];
                mode_d.sub_amp_mode_hi = MODE_RST[AMP_HI];
                mode_d.sub_amp_mode_lo = MODE_RST[AMP_LO];
                run_d.sub_osc_stop = RUN_RST[XSTOP_BIT];
            end
        end else begin
            if (mode_wr && !locked_q) begin
                mode_d = mode_wdata;
                mode_d.reserved3 = 1'b0;
                locked_d = 1'b1;
            end
            if (run_wr) begin
                run_d = run_wdata;
                run_d.reserved = '0;
            end
        end
        mode_d.reserved3 = 1'b0;
        run_d.reserved = '0;
    end

    always_ff @(posedge mclk) begin
        mode_q <= mode_d;
        run_q <= run_d;
        locked_q <= locked_d;
    end

    // Settling before the CPU may run; fast osc is the only start source
    sco_state_t state_q, state_d;
    logic [CNT_W-1:0] settle_q, settle_d;
    logic [CNT_W-1:0] ost_q, ost_d;
    sco_src_t src_q, src_d;
    logic [4:0] mhz_q, mhz_d;
    logic stable_d;
    logic slow_d;

    always_comb begin
        state_d = state_q;
        settle_d = settle_q;
        src_d = src_q;
        ost_d = ost_q;
        mhz_d = freq_decode(freq_option);
        stable_d = 1'b0;
        // Watchdog or select keeps the slow osc alive
        slow_d = wdt_running || slow_clock_source_select;
        case (state_q)
            ST_SETTLE: begin
                settle_d = settle_q + 1'b1;
                if (settle_q == CNT_W'(SETTLE_CYC - 1)) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                settle_d = settle_q;
            end
            default: begin
                state_d = ST_SETTLE;
            end
        endcase
        // Counter restarts whenever main stop is set or main pin select bit 6 is clear, so it also counts in external input mode
        if (run_q.main_osc_stop || !mode_q.main_osc_pin_select) begin
            ost_d = '0;
        end else if (ost_q != '1) begin
            ost_d = ost_q + 1'b1;
        end
        // External input is usable at once, a crystal after its count
        if (!run_q.main_osc_stop && mode_q.main_ext_clock_select && mode_q.main_osc_pin_select) begin
            stable_d = 1'b1;
        end else if (ost_q >= CNT_W'(OST_CYC)) begin
            stable_d = !run_q.main_osc_stop && mode_q.main_osc_pin_select;
        end
        // Guard: refuse a switch to a source that is not ready
        if (state_q == ST_RUN) begin
            case (cpu_src_req)
                SRC_FAST: begin
                    if (!run_q.fast_internal_osc_stop) begin
                        src_d = SRC_FAST;
                    end
                end
                SRC_MAIN: begin
                    if (main_stable) begin
                        src_d = SRC_MAIN;
                    end
                end
                SRC_SUB: begin
                    if (sub_osc_run) begin
                        src_d = SRC_SUB;
                    end
                end
                default: begin
                    src_d = src_q;
                end
            endcase
        end
        if (rst) begin
            state_d = ST_SETTLE;
            settle_d = '0;
            src_d = SRC_FAST;
            ost_d = '0;
            stable_d = 1'b0;
            slow_d = 1'b0;
        end
    end

    logic stable_q;
    logic slow_q;
    always_ff @(posedge mclk) begin
        state_q <= state_d;
        settle_q <= settle_d;
        ost_q <= ost_d;
        src_q <= src_d;
        mhz_q <= mhz_d;
        stable_q <= stable_d;
        slow_q <= slow_d;
    end

    assign clock_mode_register = mode_q;
    assign clock_run_control_register = run_q;
    assign mode_locked = locked_q;
    assign main_pins = pins_decode(mode_q.main_ext_clock_select, mode_q.main_osc_pin_select);
    assign sub_pins = pins_decode(mode_q.sub_ext_clock_select, mode_q.sub_osc_pin_select);
    assign sub_ultra_low_power = ({mode_q.sub_amp_mode_hi, mode_q.sub_amp_mode_lo} == AMP_ULP);
    assign main_osc_run = !run_q.main_osc_stop && mode_q.main_osc_pin_select;
    assign sub_osc_run = !run_q.sub_osc_stop && mode_q.sub_osc_pin_select;
    assign fast_osc_run = !run_q.fast_internal_osc_stop;
    assign fast_osc_mhz = mhz_q;
    assign fast_freq_bad = (mhz_q == 5'h00);
    assign slow_osc_run = slow_q;
    assign stabilization_counter_status = ost_q;
    assign main_stable = stable_q;
    assign cpu_run = (state_q == ST_RUN);
    assign cpu_clk_src = src_q;

endmodule : sco_clock_ctrl

// [tb/sco_xtal_model.sv]
// Behavioural main crystal: oscillation settles some cycles after enable
`timescale 1ns/1ps
module sco_xtal_model import sco_pkg::*; (
    input wire logic mclk,
    input wire logic enable,
    output logic osc_ok
);
    int n = 0;
    // Software may switch only once this reports settled
    always @(posedge mclk) begin
        n <= enable ? n + 1 : 0;
        osc_ok <= enable && (n >= OST_CYC);
    end
endmodule : sco_xtal_model

// [tb/sco_clock_ctrl_properties.sv]
// Port checker for the clock oscillator control block
`timescale 1ns/1ps
module sco_clock_ctrl_properties import sco_pkg::*; (
    input wire logic mclk,
    input wire logic rst,
    input wire logic mode_wr,
    input wire logic wdt_running,
    input wire logic slow_clock_source_select,
    input wire sco_mode_t clock_mode_register,
    input wire sco_run_t clock_run_control_register,
    input wire logic mode_locked,
    input wire sco_pins_t main_pins,
    input wire logic sub_ultra_low_power,
    input wire logic main_osc_run,
    input wire logic fast_osc_run,
    input wire logic slow_osc_run,
    input wire logic [CNT_W-1:0] stabilization_counter_status,
    input wire logic main_stable,
    input wire logic cpu_run
);
    import sco_pkg::*;
    logic [10:0] age_q, age_d;
    // Saturates so a long run cannot wrap back under the settle count
    always_comb age_d = rst ? 11'h000 : ((age_q == 11'h7FF) ? age_q : age_q + 11'h001);
    always_ff @(posedge mclk) age_q <= age_d;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    pins_port_a: assert property (main_pins.port_mode == (clock_mode_register[7:6] == PIN_PORT))
        else $error("main pins not in port mode");
    amp_ulp_a: assert property (sub_ultra_low_power == (clock_mode_register[2:1] == AMP_ULP))
        else $error("ultra low power mismatch");
    fast_stop_a: assert property (fast_osc_run == !clock_run_control_register[0])
        else $error("fast osc ignores stop bit");
    slow_on_a: assert property (wdt_running || slow_clock_source_select |=> slow_osc_run)
        else $error("slow osc not running");
    slow_off_a: assert property (!wdt_running && !slow_clock_source_select |=> !slow_osc_run)
        else $error("slow osc not stopped");
    mode_lock_a: assert property (mode_wr && mode_locked |=> $stable(clock_mode_register))
        else $error("second mode write taken");
    ext_nowait_a: assert property (main_osc_run && clock_mode_register[7:6] == PIN_EXT |=> main_stable)
        else $error("external input waited");
    xtal_wait_a: assert property (main_stable && clock_mode_register[7:6] == PIN_XTAL
        |-> stabilization_counter_status >= OST_CYC)
        else $error("crystal stable too early");
    cpu_settle_a: assert property (cpu_run |-> age_q >= SETTLE_CYC)
        else $error("cpu started before settling");
    c_cpu: cover property ($rose(cpu_run));
    c_lock: cover property (mode_wr && mode_locked);
    c_stable: cover property ($rose(main_stable));
endmodule : sco_clock_ctrl_properties
bind sco_clock_ctrl sco_clock_ctrl_properties i_props (
    .mclk(mclk), .rst(rst), .mode_wr(mode_wr), .wdt_running(wdt_running),
    .slow_clock_source_select(slow_clock_source_select), .clock_mode_register(clock_mode_register),
    .clock_run_control_register(clock_run_control_register), .mode_locked(mode_locked), .main_pins(main_pins),
    .sub_ultra_low_power(sub_ultra_low_power), .main_osc_run(main_osc_run), .fast_osc_run(fast_osc_run),
    .slow_osc_run(slow_osc_run), .stabilization_counter_status(stabilization_counter_status),
    .main_stable(main_stable), .cpu_run(cpu_run)
);

// [tb/tb_sco_clock_ctrl.sv]
// Directed bench for the clock oscillator control block
`timescale 1ns/1ps
module tb_sco_clock_ctrl;
    import sco_pkg::*;
    logic mclk = 0, rst = 1, por = 1, mode_wr = 0, run_wr = 0, wdt_running = 0, slow_clock_source_select = 0;
    sco_mode_t mode_wdata = 8'h00, clock_mode_register;
    sco_run_t run_wdata = 8'h00, clock_run_control_register;
    logic [3:0] freq_option = 4'h0;
    sco_src_t cpu_src_req = SRC_FAST, cpu_clk_src;
    sco_pins_t main_pins, sub_pins;
    logic mode_locked, sub_ultra_low_power, main_osc_run, sub_osc_run, fast_osc_run, fast_freq_bad;
    logic slow_osc_run, main_stable, cpu_run, osc_ok;
    logic [4:0] fast_osc_mhz;
    logic [CNT_W-1:0] stabilization_counter_status;
    int err_count = 0, check_count = 0;
    logic [4:0] mhz_tab [16] = '{24, 12, 6, 3, 0, 0, 0, 0, 0, 16, 8, 4, 2, 1, 0, 0};
    always #50 mclk = ~mclk;
    sco_clock_ctrl i_dut (
        .mclk(mclk), .rst(rst), .por(por), .mode_wr(mode_wr), .mode_wdata(mode_wdata), .run_wr(run_wr),
        .run_wdata(run_wdata), .freq_option(freq_option), .wdt_running(wdt_running),
        .slow_clock_source_select(slow_clock_source_select), .cpu_src_req(cpu_src_req),
        .clock_mode_register(clock_mode_register), .clock_run_control_register(clock_run_control_register),
        .mode_locked(mode_locked), .main_pins(main_pins), .sub_pins(sub_pins),
        .sub_ultra_low_power(sub_ultra_low_power), .main_osc_run(main_osc_run), .sub_osc_run(sub_osc_run),
        .fast_osc_run(fast_osc_run), .fast_osc_mhz(fast_osc_mhz), .fast_freq_bad(fast_freq_bad),
        .slow_osc_run(slow_osc_run), .stabilization_counter_status(stabilization_counter_status),
        .main_stable(main_stable), .cpu_run(cpu_run), .cpu_clk_src(cpu_clk_src)
    );
    sco_xtal_model i_xtal (.mclk(mclk), .enable(main_osc_run), .osc_ok(osc_ok));
    task results;
        if (err_count == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wait_hi(ref logic s, input int n);
        while (s !== 1'b1 && n > 0) begin @(negedge mclk); n--; end
        if (s !== 1'b1) begin err_count++; results(); end
    endtask : wait_hi
    task wr(input logic m, input logic [7:0] v);
        @(negedge mclk);
        if (m) begin mode_wr = 1; mode_wdata = v; end
        else begin run_wr = 1; run_wdata = v; end
        @(negedge mclk);
        mode_wr = 0;
        run_wr = 0;
    endtask : wr
    task do_reset(input logic p);
        por = p; rst = 1;
        repeat (2) @(negedge mclk);
        rst = 0; por = 0;
    endtask : do_reset
    initial begin
        do_reset(1);
        chk("run", RUN_RST, clock_run_control_register);
        chk("fast", 1, fast_osc_run);
        chk("cpu", 0, cpu_run);
        wait_hi(cpu_run, 1200);
        for (int i = 0; i < 16; i++) begin
            freq_option = 4'(i);
            repeat (2) @(negedge mclk);
            chk("mhz", mhz_tab[i], fast_osc_mhz);
            chk("bad", 16'(mhz_tab[i] == 5'h00), 16'(fast_freq_bad));
        end
        wr(1, 8'h54);
        wr(1, 8'hC0);
        chk("mode", 8'h54, clock_mode_register);
        chk("lock", 1, mode_locked);
        chk("pins", 4'b0101, {main_pins, sub_ultra_low_power});
        chk("spins", 3'b010, sub_pins);
        wr(0, 8'h00);
        chk("mrun", 1, main_osc_run);
        chk("srun", 1, sub_osc_run);
        cpu_src_req = SRC_MAIN;
        repeat (2) @(negedge mclk);
        chk("src", SRC_FAST, cpu_clk_src);
        wait_hi(osc_ok, 1100);
        wait_hi(main_stable, 20);
        chk("ost", OST_CYC + 1, stabilization_counter_status);
        repeat (2) @(negedge mclk);
        chk("src", SRC_MAIN, cpu_clk_src);
        cpu_src_req = SRC_SUB;
        repeat (2) @(negedge mclk);
        chk("src", SRC_SUB, cpu_clk_src);
        cpu_src_req = sco_src_t'(2'h3);
        repeat (2) @(negedge mclk);
        chk("src", SRC_SUB, cpu_clk_src);
        cpu_src_req = SRC_MAIN;
        wr(0, 8'h01);
        chk("fstop", 0, fast_osc_run);
        wdt_running = 1;
        repeat (2) @(negedge mclk);
        chk("slow", 1, slow_osc_run);
        wdt_running = 0;
        repeat (2) @(negedge mclk);
        chk("slow", 0, slow_osc_run);
        cpu_src_req = SRC_FAST;
        do_reset(0);
        chk("mode", 8'h14, clock_mode_register);
        chk("run", 8'h80, clock_run_control_register);
        chk("port", 1, main_pins.port_mode);
        chk("lock", 0, mode_locked);
        wr(1, 8'hD4);
        chk("epins", 3'b001, main_pins);
        wr(0, 8'h00);
        wait_hi(main_stable, 3);
        results();
    end
endmodule : tb_sco_clock_ctrl
